// ==== logic/spcr_cfg.svh ====
// constants of the system power, clock and reset controller
`ifndef SPCR_CFG_SVH
`define SPCR_CFG_SVH

// ********************
// timing
// ********************
`define SPCR_CLK_MHZ       100
`define SPCR_WAKE_US       35
`define SPCR_WAKE_CYC      (`SPCR_WAKE_US * `SPCR_CLK_MHZ)
`define SPCR_RST_HOLD_CYC  3'h7
`define SPCR_SWITCH_GAP    2'h2

// ********************
// divider bank
// ********************
`define SPCR_NUM_INT_DIV   12
`define SPCR_NUM_FRAC16    5
`define SPCR_INT_W         16
`define SPCR_WIDE_W        24
`define SPCR_FRAC_W        5

// ********************
// reset cause bit positions
// ********************
`define SPCR_CAUSE_POR     0
`define SPCR_CAUSE_PIN     1
`define SPCR_CAUSE_WD      2
`define SPCR_CAUSE_SW      3
`define SPCR_CAUSE_BOD     4

// ********************
// main oscillator codes: 24 MHz + 4 MHz per step
// ********************
`define SPCR_MOSC_RST      3'h0
`define SPCR_MOSC_MAX      3'h6

`endif

// ==== logic/spcr_clk_div.sv ====
// one integer or fractional divider of the high frequency clock
`timescale 1ns/10ps
`default_nettype none
`include "spcr_cfg.svh"

module spcr_clk_div #(
    parameter int WIDTH  = 16,
    parameter int FRAC_W = 5
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              en,
    input  wire logic [WIDTH-1:0]  div_int,
    input  wire logic [FRAC_W-1:0] div_frac,
    output logic                   tick
);

    // ********************
    // elaboration check
    // ********************
    if (WIDTH > `SPCR_WIDE_W || FRAC_W > `SPCR_FRAC_W
        || WIDTH < 1) begin : g_chk
        $error("spcr_clk_div: width out of range");
    end

    spcr_pkg::spcr_div_s s_r;
    spcr_pkg::spcr_div_s s_nxt;
    logic [23:0]         limit;
    logic [5:0]          sum;

    // count to div_int, plus one cycle whenever the fraction overflows
    always_comb begin
        s_nxt = s_r;
        limit = 24'(div_int) + 24'(s_r.extra);
        sum   = {1'b0, s_r.acc} + 6'(div_frac);
        s_nxt.tick = 1'b0;
        if (!en) begin
            s_nxt.cnt   = 24'h00_0000;
            s_nxt.acc   = 5'h00;
            s_nxt.extra = 1'b0;
        end else if (s_r.cnt >= limit) begin            // [R6]
            s_nxt.cnt   = 24'h00_0000;
            s_nxt.tick  = 1'b1;
            s_nxt.acc   = sum[4:0];
            s_nxt.extra = sum[5];
        end else begin
            s_nxt.cnt = s_r.cnt + 24'h00_0001;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule : spcr_clk_div
`default_nettype wire

// ==== logic/spcr_pkg.sv ====
// types of the system power, clock and reset controller
package spcr_pkg;

    typedef enum logic [2:0] {
        SPCR_HOLD,
        SPCR_ACTIVE,
        SPCR_SLEEP,
        SPCR_DEEP,
        SPCR_WAKE
    } spcr_mode_e;

    typedef struct packed {
        spcr_mode_e  mode;
        logic [11:0] wake_cnt;
        logic [2:0]  rst_cnt;
        logic        sys_rst;
        logic        cpu_clk_en;
        logic        periph_clk_en;
        logic        hf_osc_en;
        logic        cpu_pwr_en;
        logic [4:0]  cause;
        logic        dbg_dis;
        logic        sec_lock;
        logic        dbg_port_en;
        logic        prog_port_en;
        logic [2:0]  mosc_code;
        logic        mosc_lock;
        logic [1:0]  hf_sel;
        logic        hf_gate;
        logic [1:0]  sw_cnt;
        logic [15:0] wd_cnt;
        logic [2:0]  pin_s;
        logic [2:0]  bod_s;
        logic [2:0]  lpo_s;
        logic [2:0]  sup_s;
        logic [2:0]  wk_s;
    } spcr_state_s;

    typedef struct packed {
        logic [23:0] cnt;
        logic [4:0]  acc;
        logic        extra;
        logic        tick;
    } spcr_div_s;

endpackage : spcr_pkg

// ==== logic/spcr_top.sv ====
// power mode sequencer, clock control, watchdog and reset control
`timescale 1ns/10ps
`default_nettype none
`include "spcr_cfg.svh"

// Overview of operation
// R1: in active mode the cpu, memories and peripherals all get clocks.
// R2: sleep gates the cpu clock, keeps peripherals and wakes at once.
// R3: deep sleep stops the fast clock and waking takes 35 us.
// R4: mode entry waits for good supply and brown-out forces a reset.
// R5: clock source changes are glitch free and inputs are synchronised; the code synchronises only the pin, brown-out, supply, tick and wake-up inputs.
// R6: 18 dividers: 12 16-bit integer, 5 16-bit and 1 24-bit fractional.
// R7: the main oscillator starts at 24 MHz and steps 4 MHz up to 48 MHz.
// R8: the main oscillator can lock to the watch crystal when enabled.
// R9: the watchdog runs on low power oscillator ticks, resets on timeout.
// R10: each reset source is logged in a cause register that survives reset.
// R11: every reset source returns the logic to a known state.
// R12: a low level on the external reset pin resets the device.
// R13: debug is on after reset and once disabled returns only after erase.
// R14: device security permanently shuts programming, debug and test ports.
// R15: the wake-up controller wakes the cpu from deep sleep, cpu power off.
// R16: servicing the watchdog restarts its count from zero.
module spcr_top #(
    parameter int NUM_INT = `SPCR_NUM_INT_DIV,
    parameter int NUM_F16 = `SPCR_NUM_FRAC16
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ext_reset_n,
    input  wire logic                      brownout,
    input  wire logic                      supply_ok,
    input  wire logic                      low_power_osc_tick,
    input  wire logic                      wakeup_irq_ctrl,
    input  wire logic                      nested_irq_wake,
    input  wire logic                      sleep_req,
    input  wire logic                      deep_sleep_req,
    input  wire logic                      sw_reset_req,
    input  wire logic                      wd_enable,
    input  wire logic [15:0]               wd_limit,
    input  wire logic                      wd_service,
    input  wire logic                      cause_clear,
    input  wire logic                      debug_disable,
    input  wire logic                      full_erase_done,
    input  wire logic                      security_enable,
    input  wire logic [2:0]                mosc_freq_code,
    input  wire logic                      mosc_lock_en,
    input  wire logic                      watch_crystal_osc_ok,
    input  wire logic [1:0]                hf_src_req,
    input  wire logic [17:0]               div_enable,
    input  wire logic [NUM_INT-1:0][15:0]  int_div_val,
    input  wire logic [NUM_F16-1:0][15:0]  frac_div_int,
    input  wire logic [NUM_F16-1:0][4:0]   frac_div_frac,
    input  wire logic [23:0]               wide_div_int,
    input  wire logic [4:0]                wide_div_frac,
    output logic                           sys_reset,
    output logic                           cpu_clk_en,
    output logic                           periph_clk_en,
    output logic                           hf_osc_en,
    output logic                           cpu_pwr_en,
    output logic [2:0]                     power_mode,
    output logic [4:0]                     reset_cause,
    output logic                           debug_port_en,
    output logic                           prog_test_port_en,
    output logic [2:0]                     internal_main_osc_code,
    output logic                           internal_main_osc_lock,
    output logic [1:0]                     high_freq_clock_sel,
    output logic                           high_freq_clock_gate,
    output logic [15:0]                    watchdog_count,
    output logic [17:0]                    div_tick
);

    // ********************
    // elaboration check
    // ********************
    if (NUM_INT + NUM_F16 + 1 != 18) begin : g_chk
        $error("spcr_top: divider bank must hold eighteen dividers");
    end

    localparam logic [11:0] WAKE_LAST = 12'(`SPCR_WAKE_CYC - 1);

    spcr_pkg::spcr_state_s s_r;
    spcr_pkg::spcr_state_s s_nxt;
    logic                  lpo_rise;
    logic                  wd_exp;
    logic                  pin_act;
    logic                  bod_act;
    logic                  rst_evt;
    logic [4:0]            cause_set;

    // ********************
    // next state
    // ********************
    always_comb begin
        s_nxt = s_r;
        // two-flop synchronisers, third flop only for edge detect
        s_nxt.pin_s = {s_r.pin_s[1:0], ext_reset_n};                // [R5]
        s_nxt.bod_s = {s_r.bod_s[1:0], brownout};
        s_nxt.lpo_s = {s_r.lpo_s[1:0], low_power_osc_tick};
        s_nxt.sup_s = {s_r.sup_s[1:0], supply_ok};
        s_nxt.wk_s  = {s_r.wk_s[1:0], wakeup_irq_ctrl};
        lpo_rise = s_r.lpo_s[1] & ~s_r.lpo_s[2];
        pin_act  = ~s_r.pin_s[1];                                   // [R12]
        bod_act  = s_r.bod_s[1];                                    // [R4]
        wd_exp   = wd_enable & lpo_rise & ~wd_service
                   & (s_r.wd_cnt >= wd_limit);                      // [R9]
        rst_evt  = pin_act | bod_act | wd_exp | sw_reset_req;

        // sticky cause, new events win over the clear
        cause_set = 5'h00;
        cause_set[`SPCR_CAUSE_PIN] = pin_act;
        cause_set[`SPCR_CAUSE_BOD] = bod_act;
        cause_set[`SPCR_CAUSE_WD]  = wd_exp;
        cause_set[`SPCR_CAUSE_SW]   = sw_reset_req;
        s_nxt.cause = (cause_clear ? 5'h00 : s_r.cause) | cause_set; // [R10]

        // debug and security lockout
        if (full_erase_done) begin
            s_nxt.dbg_dis = 1'b0;                                   // [R13]
        end
        if (debug_disable) begin
            s_nxt.dbg_dis = 1'b1;                                   // [R13]
        end
        if (security_enable) begin
            s_nxt.sec_lock = 1'b1;                                  // [R14]
        end
        s_nxt.dbg_port_en  = ~s_nxt.dbg_dis & ~s_nxt.sec_lock;
        s_nxt.prog_port_en = ~s_nxt.sec_lock;

        // main oscillator step and watch crystal lock
        if (mosc_freq_code <= `SPCR_MOSC_MAX) begin
            s_nxt.mosc_code = mosc_freq_code;                       // [R7]
        end
        s_nxt.mosc_lock = mosc_lock_en & watch_crystal_osc_ok
                         & s_r.hf_osc_en;                           // [R8]

        // glitch-free source switch: gate off, wait, swap, gate on
        if (s_r.hf_sel != hf_src_req && s_r.hf_gate) begin
            s_nxt.hf_gate = 1'b0;                                   // [R5]
            s_nxt.sw_cnt  = `SPCR_SWITCH_GAP;
        end else if (!s_r.hf_gate && s_r.sw_cnt != 2'h0) begin
            s_nxt.sw_cnt = s_r.sw_cnt - 2'h1;
        end else if (!s_r.hf_gate) begin
            s_nxt.hf_sel  = hf_src_req;                             // [R5]
            s_nxt.hf_gate = 1'b1;
        end

        // watchdog count on low power ticks
        if (wd_service || !wd_enable) begin
            s_nxt.wd_cnt = 16'h0000;                                // [R16]
        end else if (lpo_rise) begin
            s_nxt.wd_cnt = s_r.wd_cnt + 16'h0001;                   // [R9]
        end

        // reset sequencing and power modes
        if (rst_evt) begin
            s_nxt.sys_rst       = 1'b1;                             // [R11]
            s_nxt.rst_cnt       = `SPCR_RST_HOLD_CYC;
            s_nxt.mode          = spcr_pkg::SPCR_HOLD;
            s_nxt.wd_cnt        = 16'h0000;
            s_nxt.mosc_code     = `SPCR_MOSC_RST;
            s_nxt.cpu_clk_en    = 1'b0;
            s_nxt.periph_clk_en = 1'b0;
        end else if (s_r.sys_rst) begin
            if (s_r.rst_cnt == 3'h0) begin
                s_nxt.sys_rst = 1'b0;
            end else begin
                s_nxt.rst_cnt = s_r.rst_cnt - 3'h1;
            end
        end else begin
            case (s_r.mode)
                spcr_pkg::SPCR_HOLD: begin
                    if (s_r.sup_s[1]) begin
                        s_nxt.mode = spcr_pkg::SPCR_ACTIVE;         // [R4]
                    end
                end
                spcr_pkg::SPCR_ACTIVE: begin
                    if (deep_sleep_req) begin
                        s_nxt.mode = spcr_pkg::SPCR_DEEP;
                    end else if (sleep_req) begin
                        s_nxt.mode = spcr_pkg::SPCR_SLEEP;
                    end
                end
                spcr_pkg::SPCR_SLEEP: begin
                    if (nested_irq_wake || s_r.wk_s[1]) begin
                        s_nxt.mode = spcr_pkg::SPCR_ACTIVE;         // [R2]
                    end
                end
                spcr_pkg::SPCR_DEEP: begin
                    if (s_r.wk_s[1]) begin
                        s_nxt.mode     = spcr_pkg::SPCR_WAKE;       // [R15]
                        s_nxt.wake_cnt = WAKE_LAST;
                    end
                end
                spcr_pkg::SPCR_WAKE: begin
                    if (s_r.wake_cnt == 12'h000) begin
                        s_nxt.mode = spcr_pkg::SPCR_ACTIVE;         // [R3]
                    end else begin
                        s_nxt.wake_cnt = s_r.wake_cnt - 12'h001;
                    end
                end
                default: s_nxt.mode = spcr_pkg::SPCR_HOLD;
            endcase
            s_nxt.cpu_clk_en    = (s_nxt.mode == spcr_pkg::SPCR_ACTIVE); // [R1]
            s_nxt.periph_clk_en = s_nxt.cpu_clk_en
                                  | (s_nxt.mode == spcr_pkg::SPCR_SLEEP); // [R2]
        end
        s_nxt.hf_osc_en  = (s_nxt.mode != spcr_pkg::SPCR_DEEP);     // [R3]
        s_nxt.cpu_pwr_en = (s_nxt.mode != spcr_pkg::SPCR_DEEP);     // [R15]
    end

    // ********************
    // state register, cold reset
    // ********************
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r        <= '0;
            s_r.mode   <= spcr_pkg::SPCR_HOLD;
            s_r.cause  <= 5'h01;
            s_r.pin_s  <= 3'h7;
            s_r.sys_rst <= 1'b1;
            s_r.rst_cnt <= `SPCR_RST_HOLD_CYC;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************
    // divider bank
    // ********************
    for (genvar i = 0; i < 18; i++) begin : g_div
        localparam int W = (i < NUM_INT) ? `SPCR_INT_W
                         : (i < 17) ? `SPCR_INT_W : `SPCR_WIDE_W;
        localparam int F = (i < NUM_INT) ? 1 : `SPCR_FRAC_W;
        logic [W-1:0] di;
        logic [F-1:0] df;
        if (i < NUM_INT) begin : g_int
            assign di = int_div_val[i];
            assign df = 1'b0;
        end else if (i < 17) begin : g_f16
            assign di = frac_div_int[i-NUM_INT];
            assign df = frac_div_frac[i-NUM_INT];
        end else begin : g_f24
            assign di = wide_div_int;
            assign df = wide_div_frac;
        end
        spcr_clk_div #(.WIDTH(W), .FRAC_W(F)) u_div (               // [R6]
            .clk      (clk),
            .rst      (rst | s_r.sys_rst),
            .en       (div_enable[i] & s_r.periph_clk_en & s_r.hf_gate),
            .div_int  (di),
            .div_frac (df),
            .tick     (div_tick[i])
        );
    end

    // outputs straight from the state register
    assign sys_reset              = s_r.sys_rst;
    assign cpu_clk_en             = s_r.cpu_clk_en;
    assign periph_clk_en          = s_r.periph_clk_en;
    assign hf_osc_en              = s_r.hf_osc_en;
    assign cpu_pwr_en             = s_r.cpu_pwr_en;
    assign power_mode             = s_r.mode;
    assign reset_cause            = s_r.cause;
    assign debug_port_en          = s_r.dbg_port_en;
    assign prog_test_port_en      = s_r.prog_port_en;
    assign internal_main_osc_code = s_r.mosc_code;
    assign internal_main_osc_lock = s_r.mosc_lock;
    assign high_freq_clock_sel    = s_r.hf_sel;
    assign high_freq_clock_gate   = s_r.hf_gate;
    assign watchdog_count         = s_r.wd_cnt;

    // ********************
    // assertions
    // ********************
    property p_sleep_gate;
        @(posedge clk) disable iff (rst)
        s_r.mode == spcr_pkg::SPCR_SLEEP |-> !cpu_clk_en && periph_clk_en;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) // [R2]
        else $error("sleep gating wrong");

    property p_deep_off;
        @(posedge clk) disable iff (rst)
        s_r.mode == spcr_pkg::SPCR_DEEP |-> !hf_osc_en && !cpu_pwr_en;
    endproperty
    a_deep_off: assert property (p_deep_off) // [R3]
        else $error("deep sleep clock on");

    property p_wake_len;
        @(posedge clk) disable iff (rst || s_r.sys_rst)
        s_r.mode == spcr_pkg::SPCR_DEEP && s_nxt.mode == spcr_pkg::SPCR_WAKE
        |=> s_r.wake_cnt == WAKE_LAST;
    endproperty
    a_wake_len: assert property (p_wake_len) // [R3]
        else $error("wake count wrong");

    property p_active_clk;
        @(posedge clk) disable iff (rst)
        s_r.mode == spcr_pkg::SPCR_ACTIVE && !sys_reset |-> cpu_clk_en;
    endproperty
    a_active_clk: assert property (p_active_clk) // [R1]
        else $error("active cpu gated");

    property p_wd_reset;
        @(posedge clk) disable iff (rst)
        wd_exp |=> sys_reset && reset_cause[`SPCR_CAUSE_WD];
    endproperty
    a_wd_reset: assert property (p_wd_reset) // [R9]
        else $error("watchdog no reset");

    property p_wd_service;
        @(posedge clk) disable iff (rst)
        wd_service |=> watchdog_count == 16'h0000;
    endproperty
    a_wd_service: assert property (p_wd_service) // [R16]
        else $error("service no restart");

    property p_pin_rst;
        @(posedge clk) disable iff (rst)
        !ext_reset_n [*3] |=> ##[0:1] sys_reset;
    endproperty
    a_pin_rst: assert property (p_pin_rst) // [R12]
        else $error("pin reset missed");

    property p_sec_lock;
        @(posedge clk) disable iff (rst)
        s_r.sec_lock |=> s_r.sec_lock && !prog_test_port_en;
    endproperty
    a_sec_lock: assert property (p_sec_lock) // [R14]
        else $error("security reopened");

    property p_dbg_dis;
        @(posedge clk) disable iff (rst)
        s_r.dbg_dis && !full_erase_done |=> !debug_port_en;
    endproperty
    a_dbg_dis: assert property (p_dbg_dis) // [R13]
        else $error("debug reopened");

    property p_switch;
        @(posedge clk) disable iff (rst)
        $changed(high_freq_clock_sel) |-> $past(high_freq_clock_gate) == 1'b0;
    endproperty
    a_switch: assert property (p_switch) // [R5]
        else $error("switch not gated");

endmodule : spcr_top
`default_nettype wire

// ==== verification/spcr_testbench.sv ====
// self-checking testbench of the power, clock and reset controller
`timescale 1ns/10ps
`default_nettype none
`include "spcr_cfg.svh"

module testbench;
    // ********************
    // stimulus and observed signals
    // ********************
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              ext_reset_n = 1'b1, brownout = 1'b0, supply_ok = 1'b0;
    logic              osc_tick = 1'b0, wk_wake = 1'b0, nest_wake = 1'b0;
    logic              sleep_req = 1'b0, deep_req = 1'b0, sw_rst = 1'b0;
    logic              wd_en = 1'b0, wd_svc = 1'b0, cause_clr = 1'b0;
    logic [15:0]       wd_limit = 16'h0002;
    logic              dbg_dis = 1'b0, erase_done = 1'b0, sec_en = 1'b0;
    logic [2:0]        mosc_req = 3'h0;
    logic              lock_en = 1'b0, xtal_ok = 1'b0;
    logic [1:0]        src_req = 2'h0;
    logic [17:0]       div_en = 18'h0_0000;
    logic [11:0][15:0] int_val = '0;
    logic [4:0][15:0]  f_int = '0;
    logic [4:0][4:0]   f_frac = '0;
    logic [23:0]       w_int = 24'h00_0003;
    logic [4:0]        w_frac = 5'h00;
    logic              sys_reset, cpu_clk_en, periph_clk_en, hf_osc_en;
    logic              cpu_pwr_en, dbg_en, prog_en, mosc_lock, hf_gate;
    logic [2:0]        mode, mosc_code;
    logic [4:0]        cause;
    logic [1:0]        hf_sel;
    logic [15:0]       wd_cnt;
    logic [17:0]       div_tick;
    int                mismatches = 0, checks_done = 0;

    always #5 clk = ~clk;

    spcr_top u_dut (.clk, .rst, .ext_reset_n, .brownout, .supply_ok,
        .low_power_osc_tick(osc_tick), .wakeup_irq_ctrl(wk_wake),
        .nested_irq_wake(nest_wake), .sleep_req,
        .deep_sleep_req(deep_req), .sw_reset_req(sw_rst),
        .wd_enable(wd_en), .wd_limit, .wd_service(wd_svc),
        .cause_clear(cause_clr), .debug_disable(dbg_dis),
        .full_erase_done(erase_done), .security_enable(sec_en),
        .mosc_freq_code(mosc_req), .mosc_lock_en(lock_en),
        .watch_crystal_osc_ok(xtal_ok), .hf_src_req(src_req),
        .div_enable(div_en), .int_div_val(int_val), .frac_div_int(f_int),
        .frac_div_frac(f_frac), .wide_div_int(w_int),
        .wide_div_frac(w_frac), .sys_reset, .cpu_clk_en, .periph_clk_en,
        .hf_osc_en, .cpu_pwr_en, .power_mode(mode),
        .reset_cause(cause), .debug_port_en(dbg_en),
        .prog_test_port_en(prog_en), .internal_main_osc_code(mosc_code),
        .internal_main_osc_lock(mosc_lock), .high_freq_clock_sel(hf_sel),
        .high_freq_clock_gate(hf_gate), .watchdog_count(wd_cnt),
        .div_tick);

    // ********************
    // shared helpers
    // ********************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (mode !== m && n < 5000) begin
            n++;
            cyc(1);
        end
        chk("power mode reached", 24'(m), 24'(mode));
    endtask : wait_mode

    // one low power oscillator period, slow against clk
    task automatic lp_tick();
        osc_tick = 1'b1;
        cyc(4);
        osc_tick = 1'b0;
        cyc(4);
    endtask : lp_tick

    // ********************
    // scenarios
    // ********************
    task automatic t_power_up();
        chk("mode in reset", 24'(spcr_pkg::SPCR_HOLD), 24'(mode));
        chk("cause after cold", 24'h00_0001, 24'(cause));
        cyc(30);
        chk("hold without supply", 24'(spcr_pkg::SPCR_HOLD), 24'(mode));
        supply_ok = 1'b1;
        wait_mode(spcr_pkg::SPCR_ACTIVE);
        chk("active enables", 24'h00_000f, 24'({cpu_clk_en, periph_clk_en,
            hf_osc_en, cpu_pwr_en}));
        chk("debug ports on", 24'h00_0003, 24'({dbg_en, prog_en}));
        chk("osc default", 24'h00_0000, 24'(mosc_code));
    endtask : t_power_up

    task automatic t_sleep();
        sleep_req = 1'b1;
        cyc(1);
        sleep_req = 1'b0;
        cyc(1);
        chk("sleep mode", 24'(spcr_pkg::SPCR_SLEEP), 24'(mode));
        chk("sleep clocks", 24'h00_0001,
            24'({cpu_clk_en, periph_clk_en}));
        nest_wake = 1'b1;
        cyc(2);
        nest_wake = 1'b0;
        chk("instant wake", 24'(spcr_pkg::SPCR_ACTIVE), 24'(mode));
    endtask : t_sleep

    task automatic t_deep();
        int n;
        deep_req = 1'b1;
        sleep_req = 1'b1;
        cyc(1);
        {deep_req, sleep_req} = 2'b00;
        cyc(1);
        chk("deep mode", 24'(spcr_pkg::SPCR_DEEP), 24'(mode));
        chk("deep enables", 24'h00_0000, 24'({cpu_clk_en, hf_osc_en,
            cpu_pwr_en}));
        wk_wake = 1'b1;
        wait_mode(spcr_pkg::SPCR_WAKE);
        wk_wake = 1'b0;
        n = 0;
        while (mode !== spcr_pkg::SPCR_ACTIVE && n < 5000) begin
            n++;
            cyc(1);
        end
        chk("wake cycles", 24'(`SPCR_WAKE_CYC), 24'(n));
        chk("fast osc back", 24'h00_0001, 24'(hf_osc_en));
    endtask : t_deep

    task automatic t_watchdog();
        wd_en = 1'b1;
        lp_tick();
        lp_tick();
        chk("wd count", 24'h00_0002, 24'(wd_cnt));
        wd_svc = 1'b1;
        cyc(1);
        wd_svc = 1'b0;
        cyc(1);
        chk("wd serviced", 24'h00_0000, 24'(wd_cnt));
        lp_tick();
        lp_tick();
        chk("no early reset", 24'h00_0000, 24'(sys_reset));
        lp_tick();
        chk("wd reset", 24'h00_0001, 24'(sys_reset));
        wd_en = 1'b0;
        wait_mode(spcr_pkg::SPCR_ACTIVE);
        chk("wd cause", 24'h00_0001, 24'(cause[2]));
        cause_clr = 1'b1;
        cyc(1);
        cause_clr = 1'b0;
        cyc(1);
        chk("cause cleared", 24'h00_0000, 24'(cause));
    endtask : t_watchdog

    // src 0 drives the pin low, 1 a brown-out, 2 a software reset
    task automatic t_warm(input int src, input int bit_no);
        if (src == 0) ext_reset_n = 1'b0;
        if (src == 1) brownout = 1'b1;
        if (src == 2) sw_rst = 1'b1;
        cyc(src == 2 ? 1 : 5);
        {sw_rst, brownout, ext_reset_n} = 3'b001;
        chk("warm reset", 24'h00_0001, 24'(sys_reset));
        chk("mode reset", 24'(spcr_pkg::SPCR_HOLD), 24'(mode));
        wait_mode(spcr_pkg::SPCR_ACTIVE);
        chk("cause bit", 24'h00_0001, 24'(cause[bit_no]));
    endtask : t_warm

    task automatic t_clocks();
        int n;
        mosc_req = 3'h3;
        cyc(3);
        chk("osc code", 24'h00_0003, 24'(mosc_code));
        mosc_req = 3'h7;
        cyc(3);
        chk("osc code kept", 24'h00_0003, 24'(mosc_code));
        {lock_en, xtal_ok} = 2'b11;
        cyc(3);
        chk("osc locked", 24'h00_0001, 24'(mosc_lock));
        src_req = 2'h1;
        cyc(1);
        n = 0;
        while (hf_gate !== 1'b1 && n < 20) begin
            n++;
            cyc(1);
        end
        chk("gate low cycles", 24'h00_0003, 24'(n));
        chk("new source", 24'h00_0001, 24'(hf_sel));
    endtask : t_clocks

    task automatic t_dividers();
        int c0, c12, c17;
        int_val[0] = 16'h0001;
        f_int[0] = 16'h0001;
        f_frac[0] = 5'h10;
        div_en = 18'h2_1001;
        {c0, c12, c17} = '0;
        cyc(10);
        repeat (40) begin
            cyc(1);
            c0 += int'(div_tick[0]);
            c12 += int'(div_tick[12]);
            c17 += int'(div_tick[17]);
        end
        chk("int div ticks", 24'd20, 24'(c0));
        chk("frac div ticks", 24'd16, 24'(c12));
        chk("wide div ticks", 24'd10, 24'(c17));
    endtask : t_dividers

    task automatic t_security();
        dbg_dis = 1'b1;
        cyc(1);
        dbg_dis = 1'b0;
        cyc(2);
        chk("debug off", 24'h00_0000, 24'(dbg_en));
        t_warm(0, 1);
        chk("debug off kept", 24'h00_0000, 24'(dbg_en));
        erase_done = 1'b1;
        cyc(1);
        erase_done = 1'b0;
        cyc(2);
        chk("debug after erase", 24'h00_0001, 24'(dbg_en));
        sec_en = 1'b1;
        cyc(1);
        sec_en = 1'b0;
        erase_done = 1'b1;
        cyc(2);
        erase_done = 1'b0;
        t_warm(2, 3);
        chk("ports locked", 24'h00_0000, 24'({dbg_en, prog_en}));
    endtask : t_security

    // ********************
    // sequence, verdict and watchdog
    // ********************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    initial begin
        cyc(20);
        rst = 1'b0;
        t_power_up();
        t_sleep();
        t_deep();
        t_watchdog();
        t_warm(1, 4);
        t_clocks();
        t_dividers();
        t_security();
        report_and_stop();
    end

    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
